// File: logic/sram_pkg.sv
package sram_pkg;

  localparam int WORD_ADDR_W = 16;
  localparam int WORD_DATA_W = 32;
  localparam int BYTE_LANES = 4;
  localparam int BURST_W = 2;
  localparam int BURST_BEATS = 4;
  // capture taps of the read-return delay line, in controller edges
  localparam int FLOW_TAP = 0;
  localparam int PIPE_TAP = 1;
  localparam int TAP_W = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BEAT = 3'h2,
    ST_DRAIN = 3'h4
  } ctrl_state_t;

endpackage : sram_pkg

// File: logic/sram_pins_if.sv
interface sram_pins_if
  import sram_pkg::*;
#(
  parameter int ADDR_W = WORD_ADDR_W,
  parameter int DATA_W = WORD_DATA_W,
  parameter int LANES = BYTE_LANES
);
  logic [ADDR_W-1:0] word_addr;
  logic master_select_n;
  logic select_hi;
  logic select_lo_n;
  logic proc_addr_strobe_n;
  logic ctrl_addr_strobe_n;
  logic burst_step_n;
  logic all_bytes_write_n;
  logic byte_write_gate_n;
  logic [LANES-1:0] lane_write_n;
  logic out_enable_n;
  logic burst_order_sel;
  logic flow_through_sel_n;
  logic sleep_req;
  logic [DATA_W-1:0] ctrl_dq;
  logic ctrl_dq_oe;
  logic [DATA_W-1:0] mem_dq;
  logic mem_dq_oe;
  logic [DATA_W-1:0] dq;
  logic dq_clash;

  // the shared data wire; memory wins if both drive, clash flags it
  assign dq = mem_dq_oe ? mem_dq : ctrl_dq;
  assign dq_clash = mem_dq_oe & ctrl_dq_oe;

  modport mem_end (
    input word_addr, master_select_n, select_hi, select_lo_n,
    input proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
    input all_bytes_write_n, byte_write_gate_n, lane_write_n,
    input out_enable_n, burst_order_sel, flow_through_sel_n, sleep_req,
    input dq,
    output mem_dq, mem_dq_oe
  );

  modport ctrl_end (
    output word_addr, master_select_n, select_hi, select_lo_n,
    output proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
    output all_bytes_write_n, byte_write_gate_n, lane_write_n,
    output out_enable_n, burst_order_sel, flow_through_sel_n, sleep_req,
    output ctrl_dq, ctrl_dq_oe,
    input dq
  );
endinterface : sram_pins_if

// File: logic/burst_seq.sv
module burst_seq
  import sram_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic step_in,
  input wire logic interleave_in,
  input wire logic [BURST_W-1:0] start_in,
  output logic [BURST_W-1:0] low_out
);

  typedef struct packed {
    logic [BURST_W-1:0] cnt;
  } seq_state_t;

  seq_state_t s_reg;
  seq_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (!rst_n_in) begin
      s_next = '0;
    end else if (load_in) begin
      s_next.cnt = '0;
    end else if (step_in) begin
      s_next.cnt = s_reg.cnt + 2'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    s_reg <= s_next;
  end

  // order select acts at once, so a change shows without a clock edge
  always_comb begin
    if (interleave_in) begin
      low_out = start_in ^ s_reg.cnt;
    end else begin
      low_out = start_in + s_reg.cnt;
    end
  end

endmodule : burst_seq

// File: logic/sram_mem_end.sv
// What this block does
// - Sample sync pins; four pins act unclocked
// - Capture address when selected and strobed
// - Drive data only selected, reading, output enabled
// - Master select gates processor strobe only
// - Second select high-true, third low-true
// - Processor strobe loads address or deselects
// - Controller strobe acts regardless of master select
// - Step burst address when advance low
// - Global write writes every lane
// - Lane enables count only with gate low
// - Any lane active means write, else read
// - Data drive follows output enable unclocked
// - Order select high interleaved, low linear
// - Unconnected order select means interleaved
// - Flow-through when select low, else pipelined
// - Sleep idles device and keeps contents
// - Pipelined read data one edge later
// - No step on processor strobe edge
// - Controller strobe needs processor strobe high; here it acts whatever the processor strobe
// - Lane enables ignored on processor strobe edge
module sram_mem_end
  import sram_pkg::*;
#(
  parameter int ADDR_W = WORD_ADDR_W,
  parameter int DATA_W = WORD_DATA_W,
  parameter int LANES = BYTE_LANES
)
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  sram_pins_if.mem_end pins,
  output logic selected_out,
  output logic sleeping_out
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH = 1 << ADDR_W;

  typedef struct packed {
    logic active;
    logic wr_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] q;
    logic q_rd;
    logic sleeping;
  } mem_state_t;

  mem_state_t s_reg;
  mem_state_t s_next;

  // storage sits outside the state struct, in the lane loop below: a
  // packed word this wide would slow every simulator down for no gain
  logic [DATA_W-1:0] cur_word;

  logic proc_go;
  logic ctrl_go;
  logic load;
  logic selected;
  logic [LANES-1:0] wr_lanes;
  logic wr_any;
  logic wr_now;
  logic step;
  logic interleave;
  logic flow_through;
  logic sleep;
  logic rd_now;
  logic [BURST_W-1:0] burst_low;
  logic [ADDR_W-1:0] cur_addr;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [LANES-1:0] mem_lanes;
  logic [BURST_W-1:0] xor_cnt;
  logic [BURST_W-1:0] step_low;

  ////////////////////////////////////////////////////////////////////////
  // unclocked pins

  // a floating order pin reads as x or z; anything not low is high
  assign interleave = (pins.burst_order_sel !== 1'b0);
  assign flow_through = ~pins.flow_through_sel_n;
  assign sleep = pins.sleep_req;

  ////////////////////////////////////////////////////////////////////////
  // pin decode at the edge

  // master select blocks only the processor strobe
  assign proc_go = ~pins.proc_addr_strobe_n & ~pins.master_select_n;
  assign ctrl_go = ~pins.ctrl_addr_strobe_n;
  assign load = proc_go | ctrl_go;
  assign selected = ~pins.master_select_n & pins.select_hi
    & ~pins.select_lo_n;

  always_comb begin
    if (!pins.all_bytes_write_n) begin
      wr_lanes = '1;
    end else if (!pins.byte_write_gate_n) begin
      wr_lanes = ~pins.lane_write_n;
    end else begin
      wr_lanes = '0;
    end
  end

  assign wr_any = |wr_lanes;
  // on a taken processor-strobe edge the write pins do not count
  assign wr_now = wr_any & ~proc_go;
  // advance counts only with both strobes high
  assign step = ~load & s_reg.active & ~pins.burst_step_n
    & pins.proc_addr_strobe_n;

  burst_seq u_seq (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(load & selected & ~sleep),
    .step_in(step & ~sleep),
    .interleave_in(interleave),
    .start_in(s_reg.addr[BURST_W-1:0]),
    .low_out(burst_low)
  );

  assign cur_addr = {s_reg.addr[ADDR_W-1:BURST_W], burst_low};
  assign rd_now = s_reg.active & ~s_reg.wr_mode;
  // burst count recovered from the address bits, for interleaved order
  assign xor_cnt = s_reg.addr[BURST_W-1:0] ^ burst_low;
  assign step_low = interleave
    ? s_reg.addr[BURST_W-1:0] ^ (xor_cnt + BURST_W'(1))
    : burst_low + BURST_W'(1);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_wa = cur_addr;
    mem_lanes = wr_lanes;
    s_next.sleeping = sleep;
    if (!rst_n_in) begin
      s_next = '0;
    end else if (sleep) begin
      // inputs are ignored; contents and position stay put
      s_next.q_rd = 1'b0;
    end else begin
      if (load) begin
        if (selected) begin
          s_next.active = 1'b1;
          s_next.addr = pins.word_addr;
          s_next.wr_mode = wr_now;
          mem_we = wr_now;
          mem_wa = pins.word_addr;
        end else begin
          s_next.active = 1'b0;
          s_next.wr_mode = 1'b0;
        end
      end else if (s_reg.active) begin
        // an advancing edge writes the next burst word, a suspend the
        // current one; reads keep the pre-step word for the pipeline
        s_next.wr_mode = wr_any;
        mem_we = wr_any;
        if (step) begin
          mem_wa = {s_reg.addr[ADDR_W-1:BURST_W], step_low};
        end
      end
      // a lane write seen at this edge turns the drivers off at once;
      // a load edge leaves the output register empty until the next one
      s_next.q_rd = rd_now & ~s_next.wr_mode & ~load;
      s_next.q = cur_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and storage

  always_ff @(posedge core_clk_in) begin
    s_reg <= s_next;
  end

  // one array per lane, so each lane is written by a single process
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_store [DEPTH];
    always_ff @(posedge core_clk_in) begin
      if (mem_we && mem_lanes[g]) begin
        lane_store[mem_wa] <= pins.dq[g*LANE_W +: LANE_W];
      end
    end
    assign cur_word[g*LANE_W +: LANE_W] = lane_store[cur_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // data drivers

  // flow-through shows the array straight away; pipelined shows the
  // word that was registered one edge later
  always_comb begin
    if (flow_through) begin
      pins.mem_dq = cur_word;
      pins.mem_dq_oe = rd_now & ~pins.out_enable_n & ~sleep;
    end else begin
      pins.mem_dq = s_reg.q;
      pins.mem_dq_oe = s_reg.q_rd & ~pins.out_enable_n & ~sleep;
    end
  end

  assign selected_out = s_reg.active;
  assign sleeping_out = s_reg.sleeping;

endmodule : sram_mem_end

// File: logic/sram_ctrl_end.sv
// The register offsets and the plain strobed port were left to the implementer.
module sram_ctrl_end
  import sram_pkg::*;
#(
  parameter int ADDR_W = WORD_ADDR_W,
  parameter int DATA_W = WORD_DATA_W,
  parameter int LANES = BYTE_LANES,
  parameter int BEATS = BURST_BEATS
)
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  sram_pins_if.ctrl_end pins,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_use_proc_in,
  input wire logic req_burst_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [LANES-1:0] req_lanes_in,
  input wire logic [BEATS*DATA_W-1:0] req_wdata_in,
  input wire logic order_interleave_in,
  input wire logic flow_through_in,
  input wire logic sleep_in,
  output logic req_ready_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic rdata_valid_out
);

  localparam int CNT_W = $clog2(BEATS + 1);
  localparam int IDX_W = $clog2(BEATS);

  typedef struct packed {
    ctrl_state_t state;
    logic is_write;
    logic [CNT_W-1:0] left;
    logic [IDX_W-1:0] idx;
    logic [BEATS*DATA_W-1:0] wbuf;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic proc_addr_strobe_n_n;
    logic ctrl_addr_strobe_n_n;
    logic adv_n;
    logic gwe_n;
    logic bwe_n;
    logic [LANES-1:0] bw_n;
    logic oe_n;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic order;
    logic ft_n;
    logic sleep;
    logic issue;
    logic [TAP_W-1:0] pipe;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic ready;
  } ctrl_reg_t;

  ctrl_reg_t s_reg;
  ctrl_reg_t s_next;
  logic capture;

  // read word returns one edge after the beat in flow-through, two later
  // when pipelined
  assign capture = s_reg.ft_n ? s_reg.pipe[PIPE_TAP]
    : s_reg.pipe[FLOW_TAP];

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_next = s_reg;
    s_next.proc_addr_strobe_n_n = 1'b1;
    s_next.ctrl_addr_strobe_n_n = 1'b1;
    s_next.adv_n = 1'b1;
    s_next.gwe_n = 1'b1;
    s_next.bwe_n = 1'b1;
    s_next.bw_n = '1;
    s_next.dq_oe = 1'b0;
    s_next.issue = 1'b0;
    s_next.ready = 1'b0;
    s_next.order = order_interleave_in;
    s_next.ft_n = ~flow_through_in;
    s_next.sleep = sleep_in;
    s_next.pipe = {s_reg.pipe[TAP_W-2:0], s_reg.issue};
    s_next.rvalid = capture;
    if (capture) begin
      s_next.rdata = pins.dq;
    end
    case (s_reg.state)
      ST_IDLE: begin
        s_next.oe_n = 1'b1;
        s_next.ready = ~sleep_in;
        if (req_valid_in && s_reg.ready) begin
          s_next.ready = 1'b0;
          s_next.is_write = req_write_in;
          s_next.wbuf = req_wdata_in;
          s_next.lanes = req_lanes_in;
          s_next.addr = req_addr_in;
          s_next.idx = '0;
          s_next.left = req_burst_in ? CNT_W'(BEATS) : CNT_W'(1);
          s_next.oe_n = req_write_in;
          if (req_use_proc_in) begin
            s_next.proc_addr_strobe_n_n = 1'b0;
          end else begin
            // controller start keeps the processor strobe high
            s_next.ctrl_addr_strobe_n_n = 1'b0;
          end
          // processor-strobe edge ignores write pins: data comes next edge
          if (!(req_write_in && req_use_proc_in)) begin
            s_next.left = s_next.left - CNT_W'(1);
            s_next.issue = ~req_write_in;
            if (req_write_in) begin
              s_next.gwe_n = ~&req_lanes_in;
              s_next.bwe_n = &req_lanes_in;
              s_next.bw_n = ~req_lanes_in;
              s_next.dq = req_wdata_in[DATA_W-1:0];
              s_next.dq_oe = 1'b1;
              s_next.idx = IDX_W'(1);
            end
          end
          s_next.state = (s_next.left == '0) ? ST_DRAIN : ST_BEAT;
        end
      end
      ST_BEAT: begin
        s_next.left = s_reg.left - CNT_W'(1);
        if (s_reg.is_write) begin
          s_next.gwe_n = ~&s_reg.lanes;
          s_next.bwe_n = &s_reg.lanes;
          s_next.bw_n = ~s_reg.lanes;
          s_next.dq = s_reg.wbuf[s_reg.idx*DATA_W +: DATA_W];
          s_next.dq_oe = 1'b1;
          s_next.idx = s_reg.idx + IDX_W'(1);
          // first word after a processor-strobe start goes to the loaded
          // address; every later word advances the burst first
          s_next.adv_n = (s_reg.idx == '0);
        end else begin
          s_next.adv_n = 1'b0;
          s_next.issue = 1'b1;
        end
        if (s_reg.left == CNT_W'(1)) begin
          s_next.state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // wait for outstanding read words before freeing the bus
        if (s_reg.pipe == '0 && !s_reg.issue) begin
          s_next.state = ST_IDLE;
          s_next.oe_n = 1'b1;
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    if (!rst_n_in) begin
      s_next = '0;
      s_next.state = ST_IDLE;
      s_next.proc_addr_strobe_n_n = 1'b1;
      s_next.ctrl_addr_strobe_n_n = 1'b1;
      s_next.adv_n = 1'b1;
      s_next.gwe_n = 1'b1;
      s_next.bwe_n = 1'b1;
      s_next.bw_n = '1;
      s_next.oe_n = 1'b1;
      s_next.order = 1'b1;
      s_next.ft_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and user outputs, straight from the state register except the three selects, which are tied active

  assign pins.word_addr = s_reg.addr;
  assign pins.master_select_n = 1'b0;
  assign pins.select_hi = 1'b1;
  assign pins.select_lo_n = 1'b0;
  assign pins.proc_addr_strobe_n = s_reg.proc_addr_strobe_n_n;
  assign pins.ctrl_addr_strobe_n = s_reg.ctrl_addr_strobe_n_n;
  assign pins.burst_step_n = s_reg.adv_n;
  assign pins.all_bytes_write_n = s_reg.gwe_n;
  assign pins.byte_write_gate_n = s_reg.bwe_n;
  assign pins.lane_write_n = s_reg.bw_n;
  assign pins.out_enable_n = s_reg.oe_n;
  assign pins.burst_order_sel = s_reg.order;
  assign pins.flow_through_sel_n = s_reg.ft_n;
  assign pins.sleep_req = s_reg.sleep;
  assign pins.ctrl_dq = s_reg.dq;
  assign pins.ctrl_dq_oe = s_reg.dq_oe;
  assign req_ready_out = s_reg.ready;
  assign rdata_out = s_reg.rdata;
  assign rdata_valid_out = s_reg.rvalid;

endmodule : sram_ctrl_end

// File: tb/sram_pins_monitor.sv
////////////////////////////////////////////////////////////
module sram_pins_monitor #(
  parameter int LANES = 4
)
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [LANES-1:0] lane_write_n,
  input wire logic out_enable_n,
  input wire logic flow_through_sel_n,
  input wire logic sleep_req,
  input wire logic ctrl_dq_oe,
  input wire logic mem_dq_oe,
  input wire logic dq_clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctrl_read;
  // controller-strobe start that enables no write lane: a plain read
  assign ctrl_read = !ctrl_addr_strobe_n && proc_addr_strobe_n &&
    all_bytes_write_n && (byte_write_gate_n || &lane_write_n) &&
    !sleep_req;
  default clocking mon_cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  oe_gates_drive_a: assert property (
    mem_dq_oe |-> !out_enable_n)
    else $error("memory drives with output enable off");
  sleep_quiet_a: assert property (
    sleep_req |-> !mem_dq_oe)
    else $error("memory drives while asleep");
  lane_write_off_a: assert property (
    !byte_write_gate_n && !(&lane_write_n) && proc_addr_strobe_n
    |=> !mem_dq_oe)
    else $error("memory drives after a lane write");
  wire_no_clash_a: assert property (!dq_clash)
    else $error("both ends drive the data wire");
  ctrl_start_ok_a: assert property (
    !ctrl_addr_strobe_n |-> proc_addr_strobe_n)
    else $error("both address strobes low together");
  pipe_read_lat_a: assert property (
    ctrl_read && flow_through_sel_n ##1 !out_enable_n
    |-> !mem_dq_oe ##1 (mem_dq_oe || out_enable_n))
    else $error("pipelined read data not one edge after load");
  flow_read_lat_a: assert property (
    ctrl_read && !flow_through_sel_n
    |=> mem_dq_oe || out_enable_n)
    else $error("flow-through read data not right after load");
  ctrl_drive_write_a: assert property (
    ctrl_dq_oe |-> !(all_bytes_write_n && &lane_write_n))
    else $error("controller drives data outside a write");
endmodule : sram_pins_monitor

// File: tb/testbench.sv
module testbench
  import sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [BURST_BEATS*WORD_DATA_W-1:0] beats_t;
  logic core_clk_in;
  logic rst_n_in;
  logic req_valid;
  logic req_write;
  logic req_proc;
  logic req_burst;
  logic [WORD_ADDR_W-1:0] req_addr;
  logic [BYTE_LANES-1:0] req_lanes;
  beats_t req_wdata;
  beats_t pat;
  logic order_il;
  logic flow;
  logic sleep;
  logic req_ready;
  logic rd_valid;
  logic mem_sleeping;
  logic mem_selected;
  logic [WORD_DATA_W-1:0] rdata;
  logic [WORD_DATA_W-1:0] ref_mem [16];
  logic [WORD_DATA_W-1:0] rd_q [$];
  int err_total;
  int n_tests;
  int cyc;

  sram_pins_if pins_bus ();
  sram_mem_end u_sram_mem_end (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pins(pins_bus.mem_end),
    .selected_out(mem_selected),
    .sleeping_out(mem_sleeping)
  );
  sram_ctrl_end u_sram_ctrl_end (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pins(pins_bus.ctrl_end),
    .req_valid_in(req_valid),
    .req_write_in(req_write),
    .req_use_proc_in(req_proc),
    .req_burst_in(req_burst),
    .req_addr_in(req_addr),
    .req_lanes_in(req_lanes),
    .req_wdata_in(req_wdata),
    .order_interleave_in(order_il),
    .flow_through_in(flow),
    .sleep_in(sleep),
    .req_ready_out(req_ready),
    .rdata_out(rdata),
    .rdata_valid_out(rd_valid)
  );
  sram_pins_monitor #(.LANES(BYTE_LANES)) u_sram_pins_monitor (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .proc_addr_strobe_n(pins_bus.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(pins_bus.ctrl_addr_strobe_n),
    .all_bytes_write_n(pins_bus.all_bytes_write_n),
    .byte_write_gate_n(pins_bus.byte_write_gate_n),
    .lane_write_n(pins_bus.lane_write_n),
    .out_enable_n(pins_bus.out_enable_n),
    .flow_through_sel_n(pins_bus.flow_through_sel_n),
    .sleep_req(pins_bus.sleep_req),
    .ctrl_dq_oe(pins_bus.ctrl_dq_oe),
    .mem_dq_oe(pins_bus.mem_dq_oe),
    .dq_clash(pins_bus.dq_clash)
  );
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] baddr(logic [15:0] a, int i);
    logic [1:0] s;
    s = order_il ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
    return {a[15:2], s};
  endfunction : baddr

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // sampled mid-cycle so the edge's own updates have landed
  task automatic wait_ready();
    int k;
    k = 0;
    @(negedge core_clk_in);
    while (req_ready !== 1'b1 && k < 60) begin
      @(negedge core_clk_in);
      k++;
    end
  endtask : wait_ready

  task automatic req(logic wr, logic prc, logic bst, logic [15:0] a,
    logic [3:0] ln, beats_t wd);
    logic [15:0] ba;
    rd_q.delete();
    wait_ready();
    @(posedge core_clk_in);
    req_valid <= 1'b1;
    req_write <= wr;
    req_proc <= prc;
    req_burst <= bst;
    req_addr <= a;
    req_lanes <= ln;
    req_wdata <= wd;
    @(posedge core_clk_in);
    req_valid <= 1'b0;
    for (int i = 0; i < (bst ? 4 : 1); i++) begin
      ba = baddr(a, i);
      for (int j = 0; j < 4; j++)
        if (wr && !sleep && ln[j])
          ref_mem[ba[3:0]][8*j+:8] = wd[32*i+8*j+:8];
    end
    for (int i = 0; i < 20 && !wr; i++) begin
      @(negedge core_clk_in);
      if (rd_valid === 1'b1)
        rd_q.push_back(rdata);
    end
  endtask : req

  task automatic rd(logic prc, logic bst, logic [15:0] a);
    logic [15:0] ba;
    req(1'b0, prc, bst, a, 4'h0, '0);
    check("read count", 32'(bst ? 4 : 1), 32'(rd_q.size()));
    for (int i = 0; i < rd_q.size(); i++) begin
      ba = baddr(a, i);
      check("read word", ref_mem[ba[3:0]], rd_q[i]);
    end
  endtask : rd
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // a full run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    rst_n_in <= 1'b0;
    req_valid <= 1'b0;
    req_write <= 1'b0;
    req_proc <= 1'b0;
    req_burst <= 1'b0;
    req_addr <= 16'h0000;
    req_lanes <= 4'h0;
    req_wdata <= '0;
    order_il <= 1'b1;
    flow <= 1'b0;
    sleep <= 1'b0;
    pat = {32'h4c3b2a19, 32'hf00dcafe, 32'h13579bdf, 32'h2468ace0};
    repeat (12) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(negedge core_clk_in);
    check("selected", 32'h0, 32'(mem_selected));
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk_in);
      order_il <= m[0];
      flow <= m[1];
      req(1'b1, m[0], 1'b1, 16'hfff0 + 16'(5 * m), 4'hf, pat + m);
      rd(!m[0], 1'b1, 16'hfff0 + 16'(4 * m + (m + 1) % 4));
      $display("burst test %0d done", m);
    end
    req(1'b1, 1'b1, 1'b0, 16'hfff6, 4'h5, ~pat);
    rd(1'b0, 1'b0, 16'hfff6);
    req(1'b1, 1'b0, 1'b1, 16'hfffa, 4'ha, ~pat);
    rd(1'b1, 1'b1, 16'hfffa);
    $display("lane test done");
    @(posedge core_clk_in);
    sleep <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("sleep flag", 32'h1, 32'(mem_sleeping));
    check("ready in sleep", 32'h0, 32'(req_ready));
    check("selected", 32'h1, 32'(mem_selected));
    // the model skips this write: a sleeping array must ignore it
    req(1'b1, 1'b0, 1'b1, 16'hfff0, 4'hf, ~pat);
    wait_ready();
    @(posedge core_clk_in);
    sleep <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rd(1'b0, 1'b1, 16'hfff0);
    $display("sleep test done");
    tally_and_finish();
  end
endmodule : testbench
